//--- hw/asod_pkg.sv
// Purpose: shared constants for the arithmetic slice datapath
// Assumes: one clock, synchronous resets
// Notes: select codes, widths, bus map and config layout live here only

package asod_pkg;

  // ************************************************
  // widths
  // ************************************************
  localparam int OPW = 18;
  localparam int ACCW = 48;
  localparam int CATW = 36;
  localparam int PRODW = 36;
  localparam int SELW = 7;
  localparam int SHIFT_AMT = 17;
  localparam int DEPTH_W = 2;
  localparam int BUS_W = 32;
  localparam int ADDR_W = 4;
  localparam int BE_W = 4;
  localparam int CFG_W = 8;
  localparam int RES_HI_W = ACCW - BUS_W;

  // ************************************************
  // operation select codes
  // ************************************************
  localparam logic [2:0] Z_ZERO = 3'h0;
  localparam logic [2:0] Z_CASCADE = 3'h1;
  localparam logic [2:0] Z_RESULT = 3'h2;
  localparam logic [2:0] Z_THIRD = 3'h3;
  localparam logic [2:0] Z_SH_CASCADE = 3'h5;
  localparam logic [2:0] Z_SH_RESULT = 3'h6;
  localparam logic [1:0] Y_ZERO = 2'h0;
  localparam logic [1:0] Y_PRODUCT = 2'h1;
  localparam logic [1:0] Y_ILLEGAL = 2'h2;
  localparam logic [1:0] Y_THIRD = 2'h3;
  localparam logic [1:0] X_ZERO = 2'h0;
  localparam logic [1:0] X_PRODUCT = 2'h1;
  localparam logic [1:0] X_RESULT = 2'h2;
  localparam logic [1:0] X_CONCAT = 2'h3;
  localparam logic [SELW-1:0] SEL_COUNT = 7'h20;
  localparam logic [SELW-1:0] SEL_PRELOAD = 7'h30;
  localparam logic [SELW-1:0] SEL_ACCUM = 7'h2f;

  // ************************************************
  // register map and config layout
  // ************************************************
  localparam logic [ADDR_W-1:0] OFS_CONFIG = 4'h0;
  localparam logic [ADDR_W-1:0] OFS_RES_LO = 4'h4;
  localparam logic [ADDR_W-1:0] OFS_RES_HI = 4'h8;
  localparam logic [ADDR_W-1:0] OFS_STATUS = 4'hc;
  localparam int CFG_FIRST_LSB = 0;
  localparam int CFG_SECOND_LSB = 2;
  localparam int CFG_SELECT_BIT = 4;
  localparam int CFG_THIRD_BIT = 5;
  localparam int CFG_MULT_BIT = 6;
  localparam int CFG_RESULT_BIT = 7;
  localparam logic [CFG_W-1:0] CFG_RESET = 8'hf5;
  localparam int ST_ILLEGAL_BIT = 0;
  localparam int ST_MISMATCH_BIT = 1;
  localparam int ST_W = 2;

endpackage

//--- hw/asod_pipe.sv
// Purpose: pipeline of zero, one or two registers chosen at run time
// Assumes: depth 3 behaves as depth 2
// Notes: both stages always shift under the enable, depth only picks the tap

`timescale 1ns/1ps
`default_nettype none

module asod_pipe
  import asod_pkg::*;
#(
  parameter int WIDTH = 18
) (
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic [DEPTH_W-1:0] i_depth,
  input wire logic [WIDTH-1:0] i_data,
  output logic [WIDTH-1:0] o_data
);

  logic [WIDTH-1:0] stage1_r;
  logic [WIDTH-1:0] stage2_r;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      stage1_r <= '0;
      stage2_r <= '0;
    end else if (i_ce) begin
      stage1_r <= i_data;
      stage2_r <= stage1_r;
    end
  end

  assign o_data = (i_depth == 2'h0) ? i_data : (i_depth == 2'h1) ? stage1_r : stage2_r;

endmodule

`default_nettype wire

//--- hw/asod_mult.sv
// Purpose: signed 18x18 multiplier with optional output register
// Assumes: operands are two's complement
// Notes: product is sign-extended to the adder width

`timescale 1ns/1ps
`default_nettype none

module asod_mult
  import asod_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_ce,
  input wire logic i_depth,
  input wire logic [OPW-1:0] i_first,
  input wire logic [OPW-1:0] i_second,
  output logic [ACCW-1:0] o_product
);

  logic signed [PRODW-1:0] prod;
  logic [ACCW-1:0] prod_ext;
  logic [ACCW-1:0] prod_r;

  assign prod = $signed(i_first) * $signed(i_second);
  assign prod_ext = {{(ACCW-PRODW){prod[PRODW-1]}}, prod};

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      prod_r <= '0;
    end else if (i_ce) begin
      prod_r <= prod_ext;
    end
  end

  assign o_product = i_depth ? prod_r : prod_ext;

endmodule

`default_nettype wire

//--- hw/asod_top.sv
// Purpose: arithmetic slice with multiplier, three select muxes and a 48-bit add/subtract
// Assumes: fabric drives operands and controls synchronously to i_clock
// Notes: pipeline depths are set through the Avalon-MM config register
//
// Function
// - result is z mux plus or minus the x, y and carry sum
// - subtract low adds, subtract high subtracts the summed term from z
// - select bits 6..4 pick zero, cascade, result, third, shifted cascade or result
// - select bits 3..2 pick zero, product or third; code 10 is illegal
// - select bits 1..0 pick zero, result or 36-bit operand concatenation; product code 01 gives zero
// - adder datapath and result are 48 bits wide
// - accumulate uses x 11, y 11, z 010: result plus concat plus third
// - multiply two 18-bit operands and add or subtract to z source
// - chained trees select the cascade input as z source
// - shifted z sources are arithmetic right shifts by seventeen
// - muxes are 3:1, 4:1 and 6:1; pure mux zeroes the other two
// - two-tile rotate relies on product plus shifted cascade value
// - up count: subtract 0, carry 1, select 0100000, adds one each clock
// - down count: same settings with subtract high
// - preload: select 0110000 gives third plus one, then count
// - each multiplier operand has zero, one or two pipeline registers
// - select, third, product and result each have optional register

`timescale 1ns/1ps
`default_nettype none

module asod_top
  import asod_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic [OPW-1:0] i_first_operand,
  input wire logic [OPW-1:0] i_second_operand,
  input wire logic [ACCW-1:0] i_third_operand,
  input wire logic [SELW-1:0] i_operation_select,
  input wire logic i_subtract,
  input wire logic i_carry_input,
  input wire logic [ACCW-1:0] i_cascade_input,
  input wire logic i_ce_first,
  input wire logic i_ce_second,
  input wire logic i_ce_third,
  input wire logic i_ce_select,
  input wire logic i_ce_mult,
  input wire logic i_ce_result,
  input wire logic i_rst_first,
  input wire logic i_rst_second,
  input wire logic i_rst_third,
  input wire logic i_rst_select,
  input wire logic i_rst_mult,
  input wire logic i_rst_result,
  input wire logic [ADDR_W-1:0] i_avs_address,
  input wire logic i_avs_read,
  input wire logic i_avs_write,
  input wire logic [BUS_W-1:0] i_avs_writedata,
  input wire logic [BE_W-1:0] i_avs_byteenable,
  output logic [BUS_W-1:0] o_avs_readdata,
  output logic o_avs_waitrequest,
  output logic [ACCW-1:0] o_result,
  output logic [ACCW-1:0] o_cascade_output
);

  // ************************************************
  // functions
  // ************************************************
  function automatic logic [ACCW-1:0] asod_asr(input logic [ACCW-1:0] v);
    asod_asr = {{SHIFT_AMT{v[ACCW-1]}}, v[ACCW-1:SHIFT_AMT]};
  endfunction

  function automatic logic [ACCW-1:0] asod_zext(input logic [CATW-1:0] v);
    asod_zext = {{(ACCW-CATW){1'b0}}, v};
  endfunction

  // ************************************************
  // declarations
  // ************************************************
  logic [CFG_W-1:0] cfg_r;
  logic [CFG_W-1:0] cfg_nxt;
  logic ack_r;
  logic [BUS_W-1:0] rdata_r;
  logic [BUS_W-1:0] rdata_nxt;
  logic [ACCW-1:0] result_r;
  logic [ACCW-1:0] result_nxt;
  logic [OPW-1:0] first_eff;
  logic [OPW-1:0] second_eff;
  logic [ACCW-1:0] third_eff;
  logic [ACCW-1:0] product;
  logic [SELW+1:0] ctrl_in;
  logic [SELW+1:0] ctrl_eff;
  logic [SELW-1:0] sel_eff;
  logic sub_eff;
  logic cin_eff;
  logic [2:0] z_sel;
  logic [1:0] y_sel;
  logic [1:0] x_sel;
  logic [ACCW-1:0] z_mux;
  logic [ACCW-1:0] y_mux;
  logic [ACCW-1:0] x_mux;
  logic [ACCW-1:0] term;
  logic [ST_W-1:0] status;
  logic [ACCW-1:0] out_value;

  wire bus_req = i_avs_read | i_avs_write;
  wire bus_take = bus_req & ack_r;
  wire hit_config = i_avs_address == OFS_CONFIG;
  wire hit_res_lo = i_avs_address == OFS_RES_LO;
  wire hit_res_hi = i_avs_address == OFS_RES_HI;
  wire hit_status = i_avs_address == OFS_STATUS;
  wire cfg_write = bus_take & i_avs_write & hit_config & i_avs_byteenable[0];
  wire [DEPTH_W-1:0] depth_first = cfg_r[CFG_FIRST_LSB+DEPTH_W-1:CFG_FIRST_LSB];
  wire [DEPTH_W-1:0] depth_second = cfg_r[CFG_SECOND_LSB+DEPTH_W-1:CFG_SECOND_LSB];
  wire [DEPTH_W-1:0] depth_select = {1'b0, cfg_r[CFG_SELECT_BIT]};
  wire [DEPTH_W-1:0] depth_third = {1'b0, cfg_r[CFG_THIRD_BIT]};
  wire depth_mult = cfg_r[CFG_MULT_BIT];
  wire depth_result = cfg_r[CFG_RESULT_BIT];

  // ************************************************
  // register bus slave
  // ************************************************
  // one wait state on every access keeps read data registered
  assign o_avs_waitrequest = bus_req & ~ack_r;
  assign cfg_nxt = cfg_write ? i_avs_writedata[CFG_W-1:0] : cfg_r;
  assign rdata_nxt = hit_config ? {{(BUS_W-CFG_W){1'b0}}, cfg_r} :
                     hit_res_lo ? out_value[BUS_W-1:0] :
                     hit_res_hi ? {{(BUS_W-RES_HI_W){1'b0}}, out_value[ACCW-1:BUS_W]} :
                     hit_status ? {{(BUS_W-ST_W){1'b0}}, status} : '0;

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      ack_r <= 1'b0;
      cfg_r <= CFG_RESET;
      rdata_r <= '0;
    end else begin
      ack_r <= bus_req & ~ack_r;
      cfg_r <= cfg_nxt;
      rdata_r <= (bus_req & ~ack_r) ? rdata_nxt : rdata_r;
    end
  end

  assign o_avs_readdata = rdata_r;

  // ************************************************
  // input pipelines
  // ************************************************
  assign ctrl_in = {i_subtract, i_carry_input, i_operation_select};

  asod_pipe #(.WIDTH(OPW)) u_pipe_first (
    .i_clock(i_clock),
    .i_rst(i_rst | i_rst_first),
    .i_ce(i_ce_first),
    .i_depth(depth_first),
    .i_data(i_first_operand),
    .o_data(first_eff)
  );

  asod_pipe #(.WIDTH(OPW)) u_pipe_second (
    .i_clock(i_clock),
    .i_rst(i_rst | i_rst_second),
    .i_ce(i_ce_second),
    .i_depth(depth_second),
    .i_data(i_second_operand),
    .o_data(second_eff)
  );

  asod_pipe #(.WIDTH(ACCW)) u_pipe_third (
    .i_clock(i_clock),
    .i_rst(i_rst | i_rst_third),
    .i_ce(i_ce_third),
    .i_depth(depth_third),
    .i_data(i_third_operand),
    .o_data(third_eff)
  );

  asod_pipe #(.WIDTH(SELW+2)) u_pipe_select (
    .i_clock(i_clock),
    .i_rst(i_rst | i_rst_select),
    .i_ce(i_ce_select),
    .i_depth(depth_select),
    .i_data(ctrl_in),
    .o_data(ctrl_eff)
  );

  assign sel_eff = ctrl_eff[SELW-1:0];
  assign cin_eff = ctrl_eff[SELW];
  assign sub_eff = ctrl_eff[SELW+1];

  asod_mult u_mult (
    .i_clock(i_clock),
    .i_rst(i_rst | i_rst_mult),
    .i_ce(i_ce_mult),
    .i_depth(depth_mult),
    .i_first(first_eff),
    .i_second(second_eff),
    .o_product(product)
  );

  // ************************************************
  // select multiplexers
  // ************************************************
  // three muxes, zero codes leave one live
  assign z_sel = sel_eff[6:4];
  assign y_sel = sel_eff[3:2];
  assign x_sel = sel_eff[1:0];

  // shifted cascade carries the rotate wrap bits
  always_comb begin
    case (z_sel)
      Z_ZERO: z_mux = '0;
      Z_CASCADE: z_mux = i_cascade_input;
      Z_RESULT: z_mux = result_r;
      Z_THIRD: z_mux = third_eff;
      Z_SH_CASCADE: z_mux = asod_asr(i_cascade_input);
      Z_SH_RESULT: z_mux = asod_asr(result_r);
      default: z_mux = '0;
    endcase
  end

  // y source, illegal code gives zero
  always_comb begin
    case (y_sel)
      Y_ZERO: y_mux = '0;
      Y_PRODUCT: y_mux = product;
      Y_THIRD: y_mux = third_eff;
      default: y_mux = '0;
    endcase
  end

  always_comb begin
    case (x_sel)
      X_ZERO: x_mux = '0;
      X_PRODUCT: x_mux = '0;
      X_RESULT: x_mux = result_r;
      X_CONCAT: x_mux = asod_zext({first_eff, second_eff});
      default: x_mux = '0;
    endcase
  end

  // ************************************************
  // adder / subtracter
  // ************************************************
  // product enters once through y; x product code only pairs with it
  // summed term, 48-bit width
  assign term = x_mux + y_mux + {{(ACCW-1){1'b0}}, cin_eff};
  assign result_nxt = sub_eff ? z_mux - term : z_mux + term;

  // feedback always uses the register so no combinational loop forms
  // result register enable and clear
  always_ff @(posedge i_clock) begin
    if (i_rst | i_rst_result) begin
      result_r <= '0;
    end else if (i_ce_result) begin
      result_r <= result_nxt;
    end
  end

  // optional result register on the output
  assign out_value = depth_result ? result_r : result_nxt;
  assign o_result = out_value;
  assign o_cascade_output = out_value;

  // status flags fabric misuse of select codes
  assign status[ST_ILLEGAL_BIT] = y_sel == Y_ILLEGAL;
  assign status[ST_MISMATCH_BIT] = (x_sel == X_PRODUCT) != (y_sel == Y_PRODUCT);

  // ************************************************
  // assertions
  // ************************************************
  sequence s_count_setup;
    sel_eff == SEL_COUNT && cin_eff && i_ce_result && !i_rst_result;
  endsequence

  sequence s_preload_setup;
    sel_eff == SEL_PRELOAD && cin_eff && !sub_eff && i_ce_result && !i_rst_result;
  endsequence

  AST_ADD_EXACT: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_ce_result && !i_rst_result && !sub_eff) |=>
      result_r == $past(z_mux) + $past(x_mux) + $past(y_mux) + $past({47'h0, cin_eff}))
    else $error("add result mismatch");

  AST_SUB_EXACT: assert property (@(posedge i_clock) disable iff (i_rst)
    (i_ce_result && !i_rst_result && sub_eff) |=>
      result_r == $past(z_mux) - ($past(x_mux) + $past(y_mux) + $past({47'h0, cin_eff})))
    else $error("subtract result mismatch");

  AST_Z_SHIFT: assert property (@(posedge i_clock) disable iff (i_rst)
    (z_sel == Z_SH_RESULT) |-> (z_mux[30:0] == result_r[47:17] &&
      z_mux[47:31] == {17{result_r[47]}}))
    else $error("shifted result source wrong");

  AST_Z_SH_CASCADE: assert property (@(posedge i_clock) disable iff (i_rst)
    (z_sel == Z_SH_CASCADE) |-> (z_mux[30:0] == i_cascade_input[47:17] &&
      z_mux[47:31] == {17{i_cascade_input[47]}}))
    else $error("shifted cascade source wrong");

  AST_Y_ILLEGAL: assert property (@(posedge i_clock) disable iff (i_rst)
    (y_sel == Y_ILLEGAL) |-> (y_mux == 48'h0 && status[ST_ILLEGAL_BIT]))
    else $error("illegal y code not zero");

  AST_X_CONCAT: assert property (@(posedge i_clock) disable iff (i_rst)
    (x_sel == X_CONCAT) |-> (x_mux[35:18] == first_eff && x_mux[17:0] == second_eff &&
      x_mux[47:36] == 12'h0))
    else $error("concatenated source wrong");

  AST_COUNT_UP: assert property (@(posedge i_clock) disable iff (i_rst)
    (s_count_setup and !sub_eff) |=> result_r == $past(result_r) + 48'h1)
    else $error("up count did not add one");

  AST_COUNT_DOWN: assert property (@(posedge i_clock) disable iff (i_rst)
    (s_count_setup and sub_eff) |=> result_r == $past(result_r) - 48'h1)
    else $error("down count did not subtract one");

  AST_PRELOAD: assert property (@(posedge i_clock) disable iff (i_rst)
    s_preload_setup |=> result_r == $past(third_eff) + 48'h1)
    else $error("preload not third plus one");

  AST_ACCUM: assert property (@(posedge i_clock) disable iff (i_rst)
    (sel_eff == SEL_ACCUM && !sub_eff && !cin_eff && i_ce_result && !i_rst_result) |=>
      result_r == $past(result_r) + asod_zext({$past(first_eff), $past(second_eff)}) +
        $past(third_eff))
    else $error("accumulate mismatch");

  AST_HOLD: assert property (@(posedge i_clock) disable iff (i_rst)
    (!i_ce_result && !i_rst_result) |=> $stable(result_r))
    else $error("result moved without enable");

  AST_CLEAR: assert property (@(posedge i_clock)
    (i_rst_result || i_rst) |=> result_r == 48'h0)
    else $error("result not cleared");

  AST_BUS_ONE_WAIT: assert property (@(posedge i_clock) disable iff (i_rst)
    (bus_req && o_avs_waitrequest) |=> (bus_req |-> !o_avs_waitrequest))
    else $error("bus answer late");

endmodule

`default_nettype wire

//--- testbench/asod_fabric.sv
// Purpose: neighbouring slice model that feeds the cascade input
// Assumes: signed operands, product registered on valid
// Notes: released output toggles every cycle so a stale value never looks valid

`timescale 1ns/1ps
`default_nettype none

module asod_fabric
  import asod_pkg::*;
(
  input wire logic i_clock,
  input wire logic i_rst,
  input wire logic i_valid,
  input wire logic [OPW-1:0] i_first,
  input wire logic [OPW-1:0] i_second,
  output logic [ACCW-1:0] o_cascade_output
);
  logic [ACCW-1:0] prod;

  assign prod = {{(ACCW-OPW){i_first[OPW-1]}}, i_first} *
                {{(ACCW-OPW){i_second[OPW-1]}}, i_second};

  always_ff @(posedge i_clock) begin
    if (i_rst) begin
      o_cascade_output <= '0;
    end else if (i_valid) begin
      o_cascade_output <= prod;
    end else begin
      o_cascade_output <= ~o_cascade_output;
    end
  end
endmodule

`default_nettype wire

//--- testbench/testbench.sv
// Purpose: self-checking bench for the arithmetic slice
// Assumes: all depths zero and result output tap on once configured
// Notes: each op enables the result register for exactly one edge

`timescale 1ns/1ps
`default_nettype none

module testbench;
  import asod_pkg::*;

  // ************************************************
  // signals
  // ************************************************
  logic i_clock = 1'b0;
  logic i_rst = 1'b1;
  logic [OPW-1:0] a = '0;
  logic [OPW-1:0] b = '0;
  logic [OPW-1:0] na = '0;
  logic [OPW-1:0] nb = '0;
  logic [ACCW-1:0] c = '0;
  logic [SELW-1:0] sel = '0;
  logic sub = 1'b0;
  logic carry_input = 1'b0;
  logic ce_oth = 1'b1;
  logic rst_oth = 1'b0;
  logic ce_res = 1'b0;
  logic rst_res = 1'b0;
  logic [ADDR_W-1:0] adr = '0;
  logic rd = 1'b0;
  logic wr = 1'b0;
  logic [BUS_W-1:0] wdat = '0;
  logic [BE_W-1:0] be = '0;
  logic [BUS_W-1:0] rdat;
  logic wreq;
  logic [ACCW-1:0] res;
  logic [ACCW-1:0] casc;
  logic [ACCW-1:0] cout;
  logic [ACCW-1:0] p = '0;
  int n_fail = 0;
  int compares = 0;
  int cyc = 0;
  logic [2:0] zt [6] = '{Z_ZERO, Z_CASCADE, Z_RESULT, Z_THIRD, Z_SH_CASCADE, Z_SH_RESULT};
  logic [3:0] xyt [7] = '{4'h0, 4'h2, 4'h3, 4'hc, 4'he, 4'hf, 4'h5};

  initial begin
    forever #2 i_clock = ~i_clock;
  end

  asod_top i_asod_top (
    .i_clock(i_clock), .i_rst(i_rst), .i_first_operand(a), .i_second_operand(b),
    .i_third_operand(c), .i_operation_select(sel), .i_subtract(sub), .i_carry_input(carry_input),
    .i_cascade_input(casc), .i_ce_first(ce_oth), .i_ce_second(ce_oth), .i_ce_third(ce_oth),
    .i_ce_select(ce_oth), .i_ce_mult(ce_oth), .i_ce_result(ce_res), .i_rst_first(rst_oth),
    .i_rst_second(rst_oth), .i_rst_third(rst_oth), .i_rst_select(rst_oth),
    .i_rst_mult(rst_oth), .i_rst_result(rst_res), .i_avs_address(adr), .i_avs_read(rd),
    .i_avs_write(wr), .i_avs_writedata(wdat), .i_avs_byteenable(be),
    .o_avs_readdata(rdat), .o_avs_waitrequest(wreq), .o_result(res),
    .o_cascade_output(cout)
  );

  asod_fabric i_asod_fabric (
    .i_clock(i_clock), .i_rst(i_rst), .i_valid(1'b1), .i_first(na), .i_second(nb),
    .o_cascade_output(casc)
  );

  // ************************************************
  // helpers
  // ************************************************
  function automatic logic [ACCW-1:0] f_exp(input logic [SELW-1:0] s, input logic sb,
      input logic ci, input logic [OPW-1:0] fa, input logic [OPW-1:0] fb,
      input logic [ACCW-1:0] fc, input logic [ACCW-1:0] k, input logic [ACCW-1:0] fp);
    logic [ACCW-1:0] z;
    logic [ACCW-1:0] x;
    logic [ACCW-1:0] y;
    logic [ACCW-1:0] m;
    m = {{(ACCW-OPW){fa[OPW-1]}}, fa} * {{(ACCW-OPW){fb[OPW-1]}}, fb};
    case (s[6:4])
      Z_CASCADE: z = k;
      Z_RESULT: z = fp;
      Z_THIRD: z = fc;
      Z_SH_CASCADE: z = $signed(k) >>> SHIFT_AMT;
      Z_SH_RESULT: z = $signed(fp) >>> SHIFT_AMT;
      default: z = '0;
    endcase
    y = (s[3:2] == Y_PRODUCT) ? m : (s[3:2] == Y_THIRD) ? fc : '0;
    x = (s[1:0] == X_RESULT) ? fp : (s[1:0] == X_CONCAT) ? {12'h0, fa, fb} : '0;
    return sb ? z - (x + y + ACCW'(ci)) : z + (x + y + ACCW'(ci));
  endfunction

  task automatic chk(input string nm, input logic [ACCW-1:0] e, input logic [ACCW-1:0] g);
    compares++;
    if (g !== e) begin
      n_fail++;
      $display("unexpected %s expected %h seen %h", nm, e, g);
    end
  endtask

  task automatic avs(input logic w, input logic [ADDR_W-1:0] ad, input logic [BUS_W-1:0] d,
      input logic [BE_W-1:0] e, output logic [BUS_W-1:0] q);
    @(posedge i_clock);
    rd <= ~w;
    wr <= w;
    adr <= ad;
    wdat <= d;
    be <= e;
    // waitrequest and read data are taken as they stood at the edge
    do @(posedge i_clock); while (wreq !== 1'b0);
    q = rdat;
    rd <= 1'b0;
    wr <= 1'b0;
  endtask

  task automatic nb_set(input logic [OPW-1:0] x, input logic [OPW-1:0] y);
    @(posedge i_clock);
    na <= x;
    nb <= y;
  endtask

  task automatic op(input logic [SELW-1:0] s, input logic sb, input logic ci,
      input logic [OPW-1:0] fa, input logic [OPW-1:0] fb, input logic [ACCW-1:0] fc);
    @(posedge i_clock);
    sel <= s;
    sub <= sb;
    carry_input <= ci;
    a <= fa;
    b <= fb;
    c <= fc;
    ce_oth <= 1'($urandom);
    rst_oth <= 1'($urandom);
    ce_res <= 1'b1;
    @(posedge i_clock);
    ce_res <= 1'b0;
    @(negedge i_clock);
    p = f_exp(s, sb, ci, fa, fb, fc, casc, p);
    chk("result", p, res);
    chk("cascade_output", p, cout);
  endtask

  task automatic close_out;
    $display("compares %0d n_fail %0d", compares, n_fail);
    if (n_fail == 0 && compares > 0) begin
      $display("Result: passed");
    end else begin
      $display("Result: failed");
    end
    $finish;
  endtask

  always @(posedge i_clock) begin
    cyc <= cyc + 1;
    if (cyc == 8000) begin
      n_fail++;
      close_out();
    end
  end

  // ************************************************
  // main sequence
  // ************************************************
  initial begin
    logic [BUS_W-1:0] q;
    logic [OPW-1:0] ra;
    void'($urandom(32'h30a7));
    repeat (4) @(posedge i_clock);
    i_rst <= 1'b0;
    avs(1'b0, OFS_CONFIG, '0, 4'hf, q);
    chk("config", 48'(CFG_RESET), 48'(q));
    avs(1'b0, 4'h2, '0, 4'hf, q);
    chk("unmapped", '0, 48'(q));
    avs(1'b1, OFS_CONFIG, 32'h80, 4'he, q);
    avs(1'b0, OFS_CONFIG, '0, 4'hf, q);
    chk("config", 48'(CFG_RESET), 48'(q));
    avs(1'b1, OFS_CONFIG, 32'h80, 4'h1, q);
    avs(1'b0, OFS_CONFIG, '0, 4'hf, q);
    chk("config", 48'h80, 48'(q));
    repeat (3) op(SEL_COUNT, 1'b0, 1'b1, '0, '0, '0);
    repeat (2) op(SEL_COUNT, 1'b1, 1'b1, '0, '0, '0);
    op(SEL_PRELOAD, 1'b0, 1'b1, '0, '0, 48'h7fff_0000_fffe);
    repeat (2) op(SEL_COUNT, 1'b0, 1'b1, '0, '0, '0);
    repeat (3) @(posedge i_clock);
    @(negedge i_clock);
    chk("held", p, res);
    avs(1'b0, OFS_RES_LO, '0, 4'hf, q);
    chk("res_lo", 48'(p[31:0]), 48'(q));
    avs(1'b0, OFS_RES_HI, '0, 4'hf, q);
    chk("res_hi", 48'(p[47:32]), 48'(q));
    @(posedge i_clock);
    rst_res <= 1'b1;
    ce_res <= 1'b1;
    @(posedge i_clock);
    rst_res <= 1'b0;
    ce_res <= 1'b0;
    @(negedge i_clock);
    p = '0;
    chk("cleared", p, res);
    @(posedge i_clock);
    sel <= {Z_ZERO, Y_ILLEGAL, X_ZERO};
    avs(1'b0, OFS_STATUS, '0, 4'hf, q);
    chk("status", 48'(1 << ST_ILLEGAL_BIT), 48'(q));
    sel <= SEL_COUNT;
    avs(1'b0, OFS_STATUS, '0, 4'hf, q);
    chk("status", '0, 48'(q));
    repeat (2) op(SEL_ACCUM, 1'b0, 1'b0, 18'h2_ffff, 18'h3_0001, 48'h8000_0000_0003);
    ra = 18'($urandom);
    nb_set({1'b0, ra[17:1]}, 18'h4);
    op(7'h55, 1'b0, 1'b0, ra, 18'h4, '0);
    chk("rotate", 48'({ra[15:0], ra[17:16]}), 48'(res[17:0]));
    for (int i = 0; i < 300; i++) begin
      nb_set(18'($urandom), 18'($urandom));
      // product on x and y together or not at all
      op({zt[$urandom % 6], xyt[$urandom % 7]},
         1'($urandom), 1'($urandom), 18'($urandom), 18'($urandom),
         {16'($urandom), 32'($urandom)});
    end
    // two registers on the first operand: a new value lands two edges late
    avs(1'b1, OFS_CONFIG, 32'h82, 4'h1, q);
    sel <= {Z_ZERO, Y_PRODUCT, X_PRODUCT};
    {sub, carry_input, ce_oth, rst_oth, ce_res} <= 5'b00101;
    a <= '0;
    b <= 18'h1;
    repeat (3) @(posedge i_clock);
    a <= 18'h2_0123;
    repeat (2) @(posedge i_clock);
    @(negedge i_clock);
    chk("first_pipe", '0, res);
    @(negedge i_clock);
    chk("first_pipe", 48'hffff_fffe_0123, res);
    close_out();
  end
endmodule

`default_nettype wire
